// ### hw/apts_pkg.sv
// Constants for the analog position teach and scaling block
package apts_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_PERIOD_NS = 12800;
  localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  // Filter gain per hertz: 2*pi*Ts*2^32, Ts as above
  localparam logic [31:0] BW_COEF = 32'h0005454d;
  // Voltage span in millivolts
  localparam logic signed [15:0] MV_MAX = 16'sh2710;
  localparam logic signed [15:0] MV_MIN = -16'sh2710;
  // Full scale is the command at 10 V; scale is per volt
  localparam logic signed [32:0] VT_DEN = 33'sh000002710;
  localparam logic signed [32:0] SCALE_NUM = 33'sh0000003e8;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BW = 8'h04;
  localparam logic [7:0] A_FULL = 8'h08;
  localparam logic [7:0] A_ZERO = 8'h0c;
  localparam logic [7:0] A_AMAXP = 8'h10;
  localparam logic [7:0] A_AMAXV = 8'h14;
  localparam logic [7:0] A_AMINP = 8'h18;
  localparam logic [7:0] A_AMINV = 8'h1c;
  localparam logic [7:0] A_LIMLO = 8'h20;
  localparam logic [7:0] A_LIMHI = 8'h24;
  localparam logic [7:0] A_HOME = 8'h28;
  localparam logic [7:0] A_TSEL = 8'h2c;
  localparam logic [7:0] A_POS = 8'h30;
  localparam logic [7:0] A_STEP = 8'h34;
  localparam logic [7:0] A_STAT = 8'h80;
  localparam logic [7:0] A_VRD = 8'h84;
  localparam logic [7:0] A_APOS = 8'h88;
  localparam logic [7:0] A_VT = 8'h8c;
  localparam logic [7:0] A_DAC = 8'h90;
  // Output channel blocks: 0x40 and 0x60, six words each
  localparam logic [1:0] A_OUT_PAGE = 2'b01;
  localparam logic [4:0] O_MAXVAL = 5'h00;
  localparam logic [4:0] O_MAXV = 5'h04;
  localparam logic [4:0] O_MINVAL = 5'h08;
  localparam logic [4:0] O_MINV = 5'h0c;
  localparam logic [4:0] O_OFS = 5'h10;
  localparam logic [4:0] O_SCALE = 5'h14;
  // Control fields
  localparam int C_APM_EN = 0;
  localparam int C_LIM_EN = 1;
  localparam int C_MM0 = 2;
  localparam int C_SRC0 = 4;
  // Teach select fields, min group low byte, max group high byte
  localparam int T_HOME = 0;
  localparam int T_AIN_POS = 1;
  localparam int T_AIN_V = 2;
  localparam int T_OUT0 = 3;
  localparam int T_LIM = 7;
  // Status fields
  localparam int S_PHASE = 0;
  localparam int S_LO = 1;
  localparam int S_HI = 2;
  localparam int S_MOVE = 3;
  // Reset values
  localparam logic [15:0] BW_RST = 16'h03e8;
  localparam logic [31:0] SCALE_RST = 32'h00000258;
  localparam logic [31:0] STEP_RST = 32'h00002710;
endpackage : apts_pkg

// ### hw/apts_top.sv
// Analog command filter, two-point scaling, travel clamp, teach capture and output scaling
// Function
// [RULE_01] Low-pass filter input at configured bandwidth
// [RULE_02] Scale/offset for velocity-torque, two-point for position
// [RULE_03] Add signed zero offset before scaling
// [RULE_04] Position from line through min/max points
// [RULE_05] Point positions signed revs, not limits
// [RULE_06] Point voltages within +-10 V, not clamps
// [RULE_07] Below lower limit: hold there, no fault
// [RULE_08] Above upper limit: hold there, no fault
// [RULE_09] Output scaling: scale/offset or two points
// [RULE_10] Output clamped only to +-10 V span
// [RULE_11] Output source select picks converted quantity
// [RULE_12] First teach pulse runs selected min captures
// [RULE_13] Second teach pulse runs selected max captures
// [RULE_14] Min home loads position command with home
// [RULE_15] Max home loads position command with home
// [RULE_16] Min input captures position and reading
// [RULE_17] Max input captures position and reading
// [RULE_18] Min output captures per channel
// [RULE_19] Max output captures per channel
// [RULE_20] Min limit capture loads lower limit
// [RULE_21] Max limit capture loads upper limit
// [RULE_22] Controller pulses teach twice: min, max
// [RULE_23] Enabled mode moves command to analog position
// [RULE_24] Two-point formula; teach toggles phase flag
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module apts_top #(
  parameter int SAMPLE_CYC = apts_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire logic signed [15:0] adc_mv,
  input wire logic teach_pin,
  // Internal sources for the outputs
  input wire logic signed [31:0] vel_fb,
  input wire logic signed [31:0] trq_fb,
  // Results
  output logic signed [31:0] pos_cmd,
  output logic signed [31:0] apos_cmd,
  output logic signed [31:0] vt_cmd,
  output logic signed [15:0] dac1_mv,
  output logic signed [15:0] dac2_mv,
  output logic moving,
  output logic at_lim_lo,
  output logic at_lim_hi
);

  typedef enum logic [1:0] {APTS_IDLE, APTS_LOAD, APTS_DIV, APTS_STORE} apts_state_t;

  // Saturate to the millivolt span
  function automatic logic signed [15:0] sat_mv(input logic signed [67:0] x);
    if (x > 68'(apts_pkg::MV_MAX)) sat_mv = apts_pkg::MV_MAX;
    else if (x < 68'(apts_pkg::MV_MIN)) sat_mv = apts_pkg::MV_MIN;
    else sat_mv = x[15:0];
  endfunction : sat_mv

  // Saturate to 32 bits signed
  function automatic logic signed [31:0] sat32(input logic signed [67:0] x);
    if (x > 68'sh7fffffff) sat32 = 32'sh7fffffff;
    else if (x < -68'sh80000000) sat32 = -32'sh80000000;
    else sat32 = x[31:0];
  endfunction : sat32

  logic [7:0] ctrl_q;
  logic [15:0] bw_q;
  logic signed [31:0] full_q, amaxp_q, aminp_q, limlo_q, limhi_q, home_q, step_q, pos_q;
  logic signed [15:0] zero_q, amaxv_q, aminv_q;
  logic [15:0] tsel_q;
  logic signed [31:0] o_maxval_q [2];
  logic signed [31:0] o_minval_q [2];
  logic signed [31:0] o_ofs_q [2];
  logic signed [31:0] o_scale_q [2];
  logic signed [15:0] o_maxv_q [2];
  logic signed [15:0] o_minv_q [2];
  logic phase_q;

  // Pin synchronisers
  logic signed [15:0] adc_s1_q, adc_s2_q;
  logic teach_s1_q, teach_s2_q, teach_s3_q, teach_rise;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_s1_q <= 16'sh0000;
      adc_s2_q <= 16'sh0000;
      teach_s1_q <= 1'b0;
      teach_s2_q <= 1'b0;
      teach_s3_q <= 1'b0;
    end else begin
      adc_s1_q <= adc_mv;
      adc_s2_q <= adc_s1_q;
      teach_s1_q <= teach_pin;
      teach_s2_q <= teach_s1_q;
      teach_s3_q <= teach_s2_q;
    end
  end
  assign teach_rise = teach_s2_q & ~teach_s3_q;

  // Sample tick
  logic [15:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 16'(SAMPLE_CYC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
  end

  // First-order low-pass, gain from bandwidth
  logic [47:0] kprod;
  logic [15:0] kgain;
  logic signed [31:0] filt_q;
  logic signed [32:0] fdiff;
  logic signed [49:0] fprod;
  assign kprod = 48'(bw_q) * 48'(apts_pkg::BW_COEF);
  assign kgain = (|kprod[47:32]) ? 16'hffff : kprod[31:16];
  assign fdiff = 33'($signed({adc_s2_q, 16'h0000})) - 33'(filt_q); // Keep the reading's sign
  assign fprod = fdiff * $signed({1'b0, kgain});
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) filt_q <= 32'sh00000000;
    else if (tick) filt_q <= filt_q + 32'(fprod >>> 16); // RULE_01
  end

  // Corrected converter reading
  logic signed [15:0] v_rd;
  assign v_rd = sat_mv(68'($signed(filt_q[31:16])) + 68'(zero_q)); // RULE_03

  // Output source selection
  logic signed [31:0] src_val [2];
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      unique case (ctrl_q[apts_pkg::C_SRC0 + 2*c +: 2]) // RULE_11
        2'd0: src_val[c] = pos_q;
        2'd1: src_val[c] = vel_fb;
        2'd2: src_val[c] = trq_fb;
        2'd3: src_val[c] = 32'(v_rd);
      endcase
    end
  end

  // Operands of the shared scaling job: base + (x - x0) * num / den
  apts_state_t st_q;
  logic [1:0] job_q;
  logic signed [31:0] op_base, op_x, op_x0;
  logic signed [32:0] op_num, op_den;
  logic ch;
  assign ch = job_q[0];
  always_comb begin
    op_base = 32'sh00000000;
    op_x = 32'(v_rd);
    op_x0 = 32'sh00000000;
    op_num = 33'(full_q);
    op_den = apts_pkg::VT_DEN; // RULE_02
    if (job_q == 2'd0) begin
      op_base = aminp_q; // RULE_04 RULE_24
      op_x0 = 32'(aminv_q);
      op_num = 33'(amaxp_q) - 33'(aminp_q);
      op_den = 33'(amaxv_q) - 33'(aminv_q);
    end else if (job_q[1]) begin
      op_x = src_val[ch];
      if (ctrl_q[apts_pkg::C_MM0 + 32'(ch)]) begin // RULE_09
        op_base = 32'(o_minv_q[ch]);
        op_x0 = o_minval_q[ch];
        op_num = 33'(o_maxv_q[ch]) - 33'(o_minv_q[ch]);
        op_den = 33'(o_maxval_q[ch]) - 33'(o_minval_q[ch]);
      end else begin
        op_x0 = o_ofs_q[ch];
        op_num = apts_pkg::SCALE_NUM;
        op_den = 33'(o_scale_q[ch]);
      end
    end
  end

  // Sequential divider shared by the four jobs
  logic signed [32:0] dx;
  logic signed [65:0] prod;
  logic [65:0] dv_num_q;
  logic [33:0] dv_rem_q, trial;
  logic [32:0] dv_den_q;
  logic dv_neg_q;
  logic signed [31:0] dv_base_q;
  logic [6:0] dv_cnt_q;
  logic signed [67:0] dv_res;
  assign dx = 33'(op_x) - 33'(op_x0);
  assign prod = 66'(dx) * 66'(op_num);
  assign trial = {dv_rem_q[32:0], dv_num_q[65]};
  assign dv_res = 68'(sat32((dv_neg_q ? -68'(dv_num_q) : 68'(dv_num_q)) + 68'(dv_base_q)));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= APTS_IDLE;
      job_q <= 2'd0;
      dv_num_q <= 66'h0;
      dv_rem_q <= 34'h0;
      dv_den_q <= 33'h0;
      dv_neg_q <= 1'b0;
      dv_base_q <= 32'sh00000000;
      dv_cnt_q <= 7'h00;
    end else begin
      unique case (st_q)
        APTS_IDLE: begin
          job_q <= 2'd0;
          if (tick) st_q <= APTS_LOAD;
        end
        APTS_LOAD: begin
          dv_num_q <= (op_den == 33'sh0) ? 66'h0 : (prod[65] ? 66'(-prod) : 66'(prod));
          dv_den_q <= op_den[32] ? 33'(-op_den) : 33'(op_den);
          dv_neg_q <= prod[65] ^ op_den[32];
          dv_base_q <= op_base;
          dv_rem_q <= 34'h0;
          dv_cnt_q <= 7'h00;
          st_q <= APTS_DIV;
        end
        APTS_DIV: begin
          if (trial >= {1'b0, dv_den_q}) begin
            dv_rem_q <= trial - {1'b0, dv_den_q};
            dv_num_q <= {dv_num_q[64:0], 1'b1};
          end else begin
            dv_rem_q <= trial;
            dv_num_q <= {dv_num_q[64:0], 1'b0};
          end
          dv_cnt_q <= dv_cnt_q + 7'h01;
          if (dv_cnt_q == 7'd65) st_q <= APTS_STORE;
        end
        APTS_STORE: begin
          job_q <= job_q + 2'd1;
          st_q <= (job_q == 2'd3) ? APTS_IDLE : APTS_LOAD;
        end
      endcase
    end
  end

  // Job results, travel clamp and output span clamp
  logic signed [31:0] apos_q, vt_q;
  logic signed [15:0] dac_q [2];
  logic lo_q, hi_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      apos_q <= 32'sh00000000;
      vt_q <= 32'sh00000000;
      dac_q[0] <= 16'sh0000;
      dac_q[1] <= 16'sh0000;
      lo_q <= 1'b0;
      hi_q <= 1'b0;
    end else if (st_q == APTS_STORE) begin
      unique case (job_q)
        2'd0: begin
          lo_q <= ctrl_q[apts_pkg::C_LIM_EN] && ($signed(dv_res[31:0]) < limlo_q);
          hi_q <= ctrl_q[apts_pkg::C_LIM_EN] && ($signed(dv_res[31:0]) > limhi_q);
          if (ctrl_q[apts_pkg::C_LIM_EN] && ($signed(dv_res[31:0]) < limlo_q)) apos_q <= limlo_q; // RULE_07
          else if (ctrl_q[apts_pkg::C_LIM_EN] && ($signed(dv_res[31:0]) > limhi_q)) apos_q <= limhi_q; // RULE_08
          else apos_q <= dv_res[31:0];
        end
        2'd1: vt_q <= dv_res[31:0];
        default: dac_q[job_q[0]] <= sat_mv(dv_res); // RULE_10
      endcase
    end
  end

  // AHB-Lite address phase capture and read data
  logic wr_q;
  logic [7:0] wa_q;
  logic [31:0] rd_c, rdata_q;
  logic aphase;
  assign aphase = hsel & htrans[1] & hready;
  always_comb begin
    rd_c = 32'h0;
    if (haddr[7:6] == apts_pkg::A_OUT_PAGE || haddr[7:5] == 3'b011) begin
      unique case (haddr[4:0])
        apts_pkg::O_MAXVAL: rd_c = o_maxval_q[haddr[5]];
        apts_pkg::O_MAXV: rd_c = 32'(o_maxv_q[haddr[5]]);
        apts_pkg::O_MINVAL: rd_c = o_minval_q[haddr[5]];
        apts_pkg::O_MINV: rd_c = 32'(o_minv_q[haddr[5]]);
        apts_pkg::O_OFS: rd_c = o_ofs_q[haddr[5]];
        apts_pkg::O_SCALE: rd_c = o_scale_q[haddr[5]];
        default: rd_c = 32'h0;
      endcase
    end else begin
      unique case (haddr[7:0])
        apts_pkg::A_CTRL: rd_c = 32'(ctrl_q);
        apts_pkg::A_BW: rd_c = 32'(bw_q);
        apts_pkg::A_FULL: rd_c = full_q;
        apts_pkg::A_ZERO: rd_c = 32'(zero_q);
        apts_pkg::A_AMAXP: rd_c = amaxp_q;
        apts_pkg::A_AMAXV: rd_c = 32'(amaxv_q);
        apts_pkg::A_AMINP: rd_c = aminp_q;
        apts_pkg::A_AMINV: rd_c = 32'(aminv_q);
        apts_pkg::A_LIMLO: rd_c = limlo_q;
        apts_pkg::A_LIMHI: rd_c = limhi_q;
        apts_pkg::A_HOME: rd_c = home_q;
        apts_pkg::A_TSEL: rd_c = 32'(tsel_q);
        apts_pkg::A_POS: rd_c = pos_q;
        apts_pkg::A_STEP: rd_c = step_q;
        apts_pkg::A_STAT: rd_c = {28'h0, pos_q != apos_q, hi_q, lo_q, phase_q};
        apts_pkg::A_VRD: rd_c = 32'(v_rd);
        apts_pkg::A_APOS: rd_c = apos_q;
        apts_pkg::A_VT: rd_c = vt_q;
        apts_pkg::A_DAC: rd_c = {dac_q[1], dac_q[0]};
        default: rd_c = 32'h0;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      wr_q <= aphase & hwrite;
      if (aphase) wa_q <= haddr[7:0];
      if (aphase && !hwrite) rdata_q <= rd_c;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Teach group for this pulse
  logic [7:0] tgrp;
  logic tmax;
  assign tmax = phase_q;
  assign tgrp = teach_rise ? (tmax ? tsel_q[15:8] : tsel_q[7:0]) : 8'h00; // RULE_12 RULE_13 RULE_22

  // Teach phase flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) phase_q <= 1'b0;
    else if (teach_rise) phase_q <= ~phase_q; // RULE_24
  end

  // Input configuration registers; teach capture wins over a bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 8'h00;
      bw_q <= apts_pkg::BW_RST;
      full_q <= 32'sh00000000;
      zero_q <= 16'sh0000;
      amaxp_q <= 32'sh00000000;
      aminp_q <= 32'sh00000000;
      amaxv_q <= apts_pkg::MV_MAX;
      aminv_q <= apts_pkg::MV_MIN;
      limlo_q <= 32'sh00000000;
      limhi_q <= 32'sh00000000;
      home_q <= 32'sh00000000;
      tsel_q <= 16'h0000;
      step_q <= apts_pkg::STEP_RST;
    end else begin
      if (wr_q) begin
        unique case (wa_q)
          apts_pkg::A_CTRL: ctrl_q <= hwdata[7:0];
          apts_pkg::A_BW: bw_q <= hwdata[15:0];
          apts_pkg::A_FULL: full_q <= hwdata;
          apts_pkg::A_ZERO: zero_q <= sat_mv(68'($signed(hwdata))); // RULE_03
          apts_pkg::A_AMAXP: amaxp_q <= hwdata; // RULE_05
          apts_pkg::A_AMINP: aminp_q <= hwdata; // RULE_05
          apts_pkg::A_AMAXV: amaxv_q <= sat_mv(68'($signed(hwdata))); // RULE_06
          apts_pkg::A_AMINV: aminv_q <= sat_mv(68'($signed(hwdata))); // RULE_06
          apts_pkg::A_LIMLO: limlo_q <= hwdata;
          apts_pkg::A_LIMHI: limhi_q <= hwdata;
          apts_pkg::A_HOME: home_q <= hwdata;
          apts_pkg::A_TSEL: tsel_q <= hwdata[15:0];
          apts_pkg::A_STEP: step_q <= hwdata;
          default: ;
        endcase
      end
      if (tgrp[apts_pkg::T_AIN_POS]) begin
        if (tmax) amaxp_q <= pos_q; // RULE_17
        else aminp_q <= pos_q; // RULE_16
      end
      if (tgrp[apts_pkg::T_AIN_V]) begin
        if (tmax) amaxv_q <= v_rd; // RULE_17
        else aminv_q <= v_rd; // RULE_16
      end
      if (tgrp[apts_pkg::T_LIM]) begin
        if (tmax) limhi_q <= pos_q; // RULE_21
        else limlo_q <= pos_q; // RULE_20
      end
    end
  end

  // Output channel registers with teach capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < 2; c++) begin
        o_maxval_q[c] <= 32'sh00000000;
        o_minval_q[c] <= 32'sh00000000;
        o_ofs_q[c] <= 32'sh00000000;
        o_scale_q[c] <= apts_pkg::SCALE_RST;
        o_maxv_q[c] <= apts_pkg::MV_MAX;
        o_minv_q[c] <= apts_pkg::MV_MIN;
      end
    end else begin
      if (wr_q && (wa_q[7:6] == apts_pkg::A_OUT_PAGE || wa_q[7:5] == 3'b011)) begin
        unique case (wa_q[4:0])
          apts_pkg::O_MAXVAL: o_maxval_q[wa_q[5]] <= hwdata;
          apts_pkg::O_MAXV: o_maxv_q[wa_q[5]] <= sat_mv(68'($signed(hwdata)));
          apts_pkg::O_MINVAL: o_minval_q[wa_q[5]] <= hwdata;
          apts_pkg::O_MINV: o_minv_q[wa_q[5]] <= sat_mv(68'($signed(hwdata)));
          apts_pkg::O_OFS: o_ofs_q[wa_q[5]] <= hwdata;
          apts_pkg::O_SCALE: o_scale_q[wa_q[5]] <= hwdata;
          default: ;
        endcase
      end
      for (int c = 0; c < 2; c++) begin
        if (tgrp[apts_pkg::T_OUT0 + 2*c]) begin
          if (tmax) o_maxval_q[c] <= pos_q; // RULE_19
          else o_minval_q[c] <= pos_q; // RULE_18
        end
        if (tgrp[apts_pkg::T_OUT0 + 2*c + 1]) begin
          if (tmax) o_maxv_q[c] <= v_rd; // RULE_19
          else o_minv_q[c] <= v_rd; // RULE_18
        end
      end
    end
  end

  // Position command: home on teach, rate-limited approach when enabled
  logic signed [32:0] perr;
  assign perr = 33'(apos_q) - 33'(pos_q);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_q <= 32'sh00000000;
    end else if (tgrp[apts_pkg::T_HOME]) begin
      pos_q <= home_q; // RULE_14 RULE_15
    end else if (ctrl_q[apts_pkg::C_APM_EN]) begin
      if (tick && perr != 33'sh0) begin // RULE_23
        if (perr > 33'(step_q)) pos_q <= pos_q + step_q;
        else if (perr < -33'(step_q)) pos_q <= pos_q - step_q;
        else pos_q <= apos_q;
      end
    end else if (wr_q && wa_q == apts_pkg::A_POS) begin
      pos_q <= hwdata;
    end
  end

  // Outputs
  assign pos_cmd = pos_q;
  assign apos_cmd = apos_q;
  assign vt_cmd = vt_q;
  assign dac1_mv = dac_q[0];
  assign dac2_mv = dac_q[1];
  assign moving = ctrl_q[apts_pkg::C_APM_EN] & (pos_q != apos_q);
  assign at_lim_lo = lo_q;
  assign at_lim_hi = hi_q;

endmodule : apts_top
`default_nettype wire

// ### tb/apts_asserts.sv
// Port checker for the analog position teach and scaling block
`timescale 1ns/10ps
`default_nettype none
module apts_asserts (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Results
  input wire logic signed [31:0] pos_cmd,
  input wire logic signed [31:0] apos_cmd,
  input wire logic signed [31:0] vt_cmd,
  input wire logic signed [15:0] dac1_mv,
  input wire logic signed [15:0] dac2_mv,
  input wire logic moving,
  input wire logic at_lim_lo,
  input wire logic at_lim_hi
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase taken
  wire logic rd_take = hsel & htrans[1] & hready & ~hwrite;
  // Zero-wait OKAY slave
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  // Read data only moves on a read
  AST_RD_HOLD: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved without a read");
  // Outputs within the converter span
  AST_DAC1_SPAN: assert property (dac1_mv <= apts_pkg::MV_MAX && dac1_mv >= apts_pkg::MV_MIN)
    else $error("channel 1 outside span");
  AST_DAC2_SPAN: assert property (dac2_mv <= apts_pkg::MV_MAX && dac2_mv >= apts_pkg::MV_MIN)
    else $error("channel 2 outside span");
  // Motion only while command and target differ
  AST_MOVE: assert property (moving |-> pos_cmd != apos_cmd)
    else $error("moving with equal positions");
  // Never at both travel limits
  AST_LIM_ONE: assert property (!(at_lim_lo && at_lim_hi))
    else $error("both limit flags set");
  // Position results, channel 1 output and motion flag cleared out of reset
  AST_RST_CLR: assert property ($rose(hresetn) |-> pos_cmd == 0 && apos_cmd == 0 && dac1_mv == 0 && !moving)
    else $error("results not cleared by reset");
  // Analog position and velocity command hold at least 8 cycles after each update
  AST_APOS_HOLD: assert property ($changed(apos_cmd) |=> $stable(apos_cmd) [*8])
    else $error("analog position updated twice");
  AST_VT_HOLD: assert property ($changed(vt_cmd) |=> $stable(vt_cmd) [*8])
    else $error("velocity command updated twice");
endmodule : apts_asserts
bind apts_top apts_asserts u_apts_asserts (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .pos_cmd, .apos_cmd, .vt_cmd, .dac1_mv, .dac2_mv, .moving,
  .at_lim_lo, .at_lim_hi);
`default_nettype wire

// ### tb/apts_top_tb.sv
// Self-checking bench for the analog position teach and scaling block
`timescale 1ns/10ps
`default_nettype none
module apts_top_tb;
  localparam int SCYC = 300;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic signed [15:0] adc_mv = 16'sh0834;
  logic teach_pin = 1'b0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic signed [31:0] pos_cmd;
  wire logic signed [31:0] apos_cmd;
  wire logic signed [31:0] vt_cmd;
  wire logic signed [15:0] dac1_mv;
  wire logic signed [15:0] dac2_mv;
  wire logic moving;
  wire logic at_lim_lo;
  wire logic at_lim_hi;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h34, 8'h44, 8'h4c, 8'h54, 8'hfc};
  logic [31:0] rv [11] = '{32'h0, 32'h3e8, 32'h0, 32'h2710, 32'h0, 32'hffffd8f0, 32'h2710,
    32'h2710, 32'hffffd8f0, 32'h258, 32'h0};
  // Clock
  always #12.5 hclk = ~hclk;
  // Design under test
  apts_top #(.SAMPLE_CYC(SCYC)) u_apts_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .adc_mv, .teach_pin,
    .vel_fb(32'sh00000bb8), .trq_fb(-32'sh00000005), .pos_cmd, .apos_cmd, .vt_cmd, .dac1_mv,
    .dac2_mv, .moving, .at_lim_lo, .at_lim_hi);
  task automatic final_report;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g, input int tol = 0);
    compares++;
    if ($isunknown(g) || $signed(g - e) > tol || $signed(e - g) > tol) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One single-word transfer, held until ready at each phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    if (hclk !== 1'b1) @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input int tol = 0);
    bus(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), e, q, tol);
  endtask : rc
  // Wait whole samples, then settle off the edge
  task automatic tick(input int n);
    repeat (n * SCYC) @(posedge hclk);
    @(negedge hclk);
  endtask : tick
  task automatic pulse;
    teach_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    teach_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    tick(0);
  endtask : pulse
  // Cycle ceiling
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) rc(ra[i], rv[i]);
    wr(8'h04, 32'ha);
    tick(5);
    rc(8'h84, 32'hc8, 200);
    wr(8'h04, 32'hffff);
    wr(8'h0c, 32'h4e20);
    rc(8'h0c, 32'h2710);
    wr(8'h0c, 32'hffffff9c);
    wr(8'h08, 32'h1388);
    wr(8'h10, 32'h186a0);
    tick(6);
    rc(8'h84, 32'h7d0, 2);
    chk("vt_cmd", 32'h3e8, vt_cmd, 2);
    chk("apos_cmd", 32'hea60, apos_cmd, 12);
    wr(8'h20, 32'h2710);
    wr(8'h24, 32'hc350);
    wr(8'h00, 32'h2);
    tick(2);
    chk("apos_cmd", 32'hc350, apos_cmd);
    chk("at_lim_hi", 32'h1, at_lim_hi);
    wr(8'h20, 32'h11170);
    wr(8'h24, 32'h15f90);
    tick(2);
    chk("apos_cmd", 32'h11170, apos_cmd);
    chk("at_lim_lo", 32'h1, at_lim_lo);
    wr(8'h20, 32'h2710);
    wr(8'h24, 32'hc350);
    wr(8'h00, 32'h3);
    tick(0);
    chk("moving", 32'h1, moving);
    tick(8);
    chk("pos_cmd", 32'hc350, pos_cmd);
    chk("moving", 32'h0, moving);
    wr(8'h30, 32'h7b);
    rc(8'h30, 32'hc350);
    wr(8'h00, 32'h2);
    wr(8'h30, 32'h4e20);
    wr(8'h2c, 32'ha58a);
    wr(8'h28, 32'h1e61);
    pulse();
    rc(8'h18, 32'h4e20);
    rc(8'h48, 32'h4e20);
    rc(8'h20, 32'h4e20);
    rc(8'h1c, 32'hffffd8f0);
    rc(8'h68, 32'h0);
    chk("pos_cmd", 32'h4e20, pos_cmd);
    bus(8'h80, 1'b0, 32'h0);
    chk("phase", 32'h1, {31'h0, q[0]});
    wr(8'h30, 32'h7530);
    pulse();
    chk("pos_cmd", 32'h1e61, pos_cmd);
    rc(8'h14, 32'h7d0, 2);
    rc(8'h60, 32'h7530);
    rc(8'h10, 32'h186a0);
    rc(8'h24, 32'h7530);
    bus(8'h80, 1'b0, 32'h0);
    chk("phase", 32'h0, {31'h0, q[0]});
    wr(8'h30, 32'h1);
    wr(8'h2c, 32'h1);
    pulse();
    chk("pos_cmd", 32'h1e61, pos_cmd);
    wr(8'h00, 32'h4a);
    tick(2);
    chk("dac1_mv", 32'h2710, dac1_mv);
    chk("dac2_mv", 32'hffffe0c0, dac2_mv);
    wr(8'h00, 32'hb0);
    tick(2);
    chk("dac1_mv", 32'hd05, dac1_mv, 4);
    chk("dac2_mv", 32'hfffffff8, dac2_mv);
    final_report();
  end
endmodule : apts_top_tb
`default_nettype wire
